/* bench/lmsq_host_model.sv */
/*
  Serial bus host model: register writes and single-byte reads.
  Assumes the bench builds the open-drain data line with a pull-up.
*/
`timescale 1ns/10ps
module lmsq_host_model #(
  parameter logic [6:0] ADDR = lmsq_pkg::SLAVE_ADDR_DEFAULT,
  parameter int EN_WAIT = 5000
) (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  int en_cnt = 0;
  int nacks = 0;
  // ********
  // bus phases, each change made just after a clock edge
  // ********
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  always @(posedge i_clk) en_cnt <= i_en ? en_cnt + 1 : 0;
  task automatic wt(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic sc(input logic v, input int k);
    o_scl <= v;
    wt(k);
  endtask
  task automatic sd(input logic low, input int k);
    o_sda_low <= low;
    wt(k);
  endtask
  // data moves only while the clock is low, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    sd(~b, 5);
    sc(1'b1, 5);
    s = i_sda;
    wt(5);
    sc(1'b0, 5);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic wr, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(1'b1, a);
    if (wr && a) nacks++;
  endtask
  task automatic start(input logic rep);
    wt(1);
    while (i_en && en_cnt < EN_WAIT) wt(1);
    if (rep) begin
      sd(1'b0, 5);
      sc(1'b1, 10);
    end
    sd(1'b1, 10);
    sc(1'b0, 5);
  endtask
  task automatic stop();
    sd(1'b1, 5);
    sc(1'b1, 10);
    sd(1'b0, 20);
  endtask
  task automatic head(input logic [7:0] a);
    logic [7:0] r;
    start(1'b0);
    byte_io({ADDR, 1'b0}, 1'b1, r);
    byte_io(a, 1'b1, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    head(a);
    byte_io(d, 1'b1, r);
    stop();
  endtask
  // one byte read, ended by a host not-acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    head(a);
    start(1'b1);
    byte_io({ADDR, 1'b1}, 1'b1, r);
    byte_io(8'hff, 1'b0, d);
    stop();
  endtask
endmodule

/* bench/lmsq_top_bench.sv */
/*
  Self-checking bench of the mode sequencer through pins and the host model.
  Assumes the bound checker and a 10 MHz clock.
*/
`timescale 1ns/10ps
module lmsq_top_bench;
  import lmsq_pkg::*;
  localparam int SU = 8;
  logic clk, rst, en, ot, led, pclk, scl, sda_low, sda_oe, sda_out;
  logic run, ana, osc, lede, tick, seen_rst;
  logic [7:0] cfg, rd;
  lmsq_pkg::lmsq_mode_type mode;
  int err_total, checked, cyc, n, ticks, t0, su_n, su_last;
  wire sda;
  // open-drain data line with pull-up
  assign sda = ~sda_low & (~sda_oe | sda_out);
  lmsq_top #(.STARTUP_CYCLES(SU)) dut (.i_clk(clk), .i_sys_rst(rst), .i_en_pin(en),
    .i_over_temp(ot), .i_led_active(led), .i_prog_clk(pclk), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_out), .o_sda_oe(sda_oe), .o_mode(mode), .o_run(run), .o_analog_en(ana),
    .o_osc_en(osc), .o_led_en(lede), .o_config(cfg), .o_prog_tick(tick));
  lmsq_host_model host (.i_clk(clk), .i_en(en), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ********
  // monitors: startup length, reset sightings, ticks, timeout
  // ********
  always @(posedge clk) begin
    cyc <= cyc + 1;
    su_n <= (mode === MODE_STARTUP) ? su_n + 1 : 0;
    if (mode === MODE_STARTUP) su_last <= su_n + 1;
    if (mode === MODE_RESET) seen_rst <= 1'b1;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_mode(input lmsq_mode_type m);
    n = 0;
    #1;
    while (mode !== m && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic pulses(input int k, input int h);
    repeat (k) begin
      pclk <= 1'b1;
      step(h);
      pclk <= 1'b0;
      step(h);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    en = 1'b0;
    ot = 1'b0;
    led = 1'b1;
    pclk = 1'b0;
    seen_rst = 1'b0;
    step(2);
    rst <= 1'b0;
    #1 chk("por mode", 8'(mode), 8'(MODE_RESET));
    step(3);
    #1 chk("mode after por", 8'(mode), 8'(MODE_STANDBY));
    chk("run after por", 8'(run), 8'h00);
    host.wr(REG_CTRL, 8'h01);
    step(10);
    #1 chk("run en low", 8'(run), 8'h00);
    chk("mode en low", 8'(mode), 8'(MODE_STANDBY));
    step(1);
    en <= 1'b1;
    host.wr(REG_CONFIG, 8'h5a);
    step(5);
    #1 chk("cfg standby", cfg, 8'h00);
    chk("analog standby", 8'(ana), 8'h00);
    host.rd(REG_CONFIG, rd);
    chk("cfg read", rd, 8'h5a);
    host.rd(REG_SW_RESET, rd);
    chk("trigger read", rd, READ_ZERO);
    host.rd(8'h20, rd);
    chk("unmapped read", rd, READ_ZERO);
    host.wr(REG_CTRL, 8'h01);
    wait_mode(MODE_NORMAL);
    chk("startup length", 8'(su_last), 8'(SU));
    chk("led normal", 8'(lede), 8'h01);
    chk("cfg normal", cfg, 8'h5a);
    host.rd(REG_STATUS, rd);
    chk("status read", rd, 8'(MODE_NORMAL));
    step(1);
    led <= 1'b0;
    step(3);
    #1 chk("mode leds idle", 8'(mode), 8'(MODE_PSAVE));
    chk("analog psave", 8'(ana), 8'h00);
    t0 = ticks;
    step(1);
    pulses(4, 20);
    led <= 1'b1;
    pulses(4, 6);
    step(5);
    #1 chk("ticks", 8'(ticks - t0), 8'h08);
    chk("mode leds on", 8'(mode), 8'(MODE_NORMAL));
    step(1);
    ot <= 1'b1;
    step(40);
    #1 chk("mode hot", 8'(mode), 8'(MODE_STARTUP));
    chk("analog hot", 8'(ana), 8'h01);
    step(1);
    ot <= 1'b0;
    wait_mode(MODE_NORMAL);
    chk("mode cooled", 8'(mode), 8'(MODE_NORMAL));
    chk("cool delay", 8'(n > SU), 8'h01);
    step(1);
    ot <= 1'b1;
    en <= 1'b0;
    step(8);
    #1 chk("mode en low hot", 8'(mode), 8'(MODE_STANDBY));
    t0 = ticks;
    step(1);
    pulses(3, 10);
    #1 chk("ticks standby", 8'(ticks - t0), 8'h00);
    step(1);
    ot <= 1'b0;
    en <= 1'b1;
    wait_mode(MODE_NORMAL);
    chk("mode en back", 8'(mode), 8'(MODE_NORMAL));
    step(1);
    seen_rst <= 1'b0;
    host.wr(REG_SW_RESET, 8'h55);
    step(5);
    #1 chk("wrong key", 8'(seen_rst), 8'h00);
    host.wr(REG_SW_RESET, SW_RESET_KEY);
    step(5);
    #1 chk("key reset", 8'(seen_rst), 8'h01);
    chk("mode after key", 8'(mode), 8'(MODE_STANDBY));
    chk("run after key", 8'(run), 8'h00);
    host.rd(REG_CONFIG, rd);
    chk("cfg after key", rd, CONFIG_RESET_VAL);
    host.wr(REG_CTRL, 8'h01);
    wait_mode(MODE_NORMAL);
    step(1);
    rst <= 1'b1;
    step(2);
    rst <= 1'b0;
    #1 chk("por mid run", 8'(mode), 8'(MODE_RESET));
    step(3);
    #1 chk("mode after por", 8'(mode), 8'(MODE_STANDBY));
    chk("run after por", 8'(run), 8'h00);
    chk("host nacks", 8'(host.nacks), 8'h00);
    end_sim();
  end
endmodule

/* bench/lmsq_top_sva.sv */
/*
  Port checks of the mode sequencer, bound into lmsq_top.
  Assumes one system clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module lmsq_top_sva #(
  parameter int STARTUP_CYCLES = lmsq_pkg::STARTUP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_en_pin,
  input wire logic i_over_temp,
  input wire logic i_led_active,
  input wire lmsq_pkg::lmsq_mode_type o_mode,
  input wire logic o_run,
  input wire logic o_analog_en,
  input wire logic o_osc_en,
  input wire logic o_led_en,
  input wire logic [7:0] o_config,
  input wire logic o_prog_tick
);
  import lmsq_pkg::*;
  logic [15:0] su_cnt_q;
  logic [15:0] su_cnt_d;
  // ********
  // startup stay counter
  // ********
  always_comb begin
    su_cnt_d = (o_mode == MODE_STARTUP) ? su_cnt_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge i_clk) begin
    su_cnt_q <= i_sys_rst ? 16'h0000 : su_cnt_d;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // pin levels held long enough to pass the input synchronisers
  sequence s_hot;
    i_over_temp [*5];
  endsequence
  sequence s_en_low;
    (!i_en_pin) [*5];
  endsequence
  sequence s_armed;
    (o_run && i_en_pin) [*4] ##0 o_mode == MODE_STANDBY;
  endsequence
  a_por_hold: assert property (disable iff (1'b0) i_sys_rst |=> o_mode == MODE_RESET)
    else $error("mode not reset under power-on reset");
  a_reset_exit: assert property (o_mode == MODE_RESET |=> o_mode == MODE_STANDBY)
    else $error("reset not followed by standby");
  a_reset_clear: assert property (o_mode == MODE_RESET |=> !o_run && o_config == 8'h00)
    else $error("registers not cleared by reset");
  a_stby_off: assert property (o_mode == MODE_STANDBY |-> !o_analog_en && !o_osc_en && !o_led_en)
    else $error("functions on in standby");
  a_en_low: assert property (s_en_low |-> o_mode inside {MODE_STANDBY, MODE_RESET})
    else $error("enable low but not standby");
  a_run_start: assert property (s_armed |=> o_mode == MODE_STARTUP)
    else $error("startup not entered");
  a_su_len: assert property (o_mode inside {MODE_NORMAL, MODE_PSAVE} &&
    $past(o_mode) == MODE_STARTUP |-> su_cnt_q >= STARTUP_CYCLES) else $error("startup too short");
  a_hot_hold: assert property (s_hot |-> !(o_mode inside {MODE_NORMAL, MODE_PSAVE}))
    else $error("running while hot");
  a_normal_on: assert property (o_mode == MODE_NORMAL |-> o_led_en && o_analog_en && o_osc_en)
    else $error("normal without enables");
  a_psave_in: assert property (o_mode == MODE_NORMAL && !i_led_active |=> o_mode != MODE_NORMAL)
    else $error("no power save with leds idle");
  a_psave_off: assert property (o_mode == MODE_PSAVE |-> !o_analog_en && !o_led_en)
    else $error("analog on in power save");
  a_tick_pulse: assert property (o_prog_tick |=> !o_prog_tick)
    else $error("tick longer than one cycle");
  a_tick_gate: assert property ((o_mode == MODE_STANDBY) [*2] |-> !o_prog_tick)
    else $error("tick in standby");
endmodule
bind lmsq_top lmsq_top_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_sva (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en_pin(i_en_pin), .i_over_temp(i_over_temp),
  .i_led_active(i_led_active), .o_mode(o_mode), .o_run(o_run), .o_analog_en(o_analog_en),
  .o_osc_en(o_osc_en), .o_led_en(o_led_en), .o_config(o_config), .o_prog_tick(o_prog_tick));

/* core/lmsq_prog_tick.sv */
/*
  Program timebase: turns each rising edge of the external program clock
  into one system-clock pulse. Assumes the external clock is far slower
  than the system clock and asynchronous to it.
*/
`timescale 1ns/10ps
module lmsq_prog_tick (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_prog_clk,
  input wire logic i_enable,
  output logic o_tick
);
  import lmsq_pkg::*;

  logic sync1_q, sync2_q, prev_q, tick_q;
  logic sync1_d, sync2_d, prev_d, tick_d;

  // ************************************************************
  // two-stage synchroniser and rising edge detect
  // ************************************************************
  always_comb begin
    sync1_d = i_prog_clk;
    sync2_d = sync1_q;
    prev_d = sync2_q;
    tick_d = i_enable & sync2_q & ~prev_q; // RULE12
  end

  // registers only
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
endmodule

/* core/lmsq_ser_slave.sv */
/*
  Two-wire serial register slave: address byte, register pointer, then
  write data with auto increment, or read data after a repeated start.
  Assumes pins are asynchronous; SCL and SDA are synchronised here.
*/
`timescale 1ns/10ps
module lmsq_ser_slave #(
  parameter logic [6:0] SLAVE_ADDR = lmsq_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  lmsq_reg_if.slave bus
);
  import lmsq_pkg::*;

  logic [1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d; // {scl, sda}
  lmsq_ser_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, rsh_q, rsh_d, ptr_q, ptr_d;
  logic oe_q, oe_d, stb_q, stb_d;
  logic rise, fall, start, stop;

  // ************************************************************
  // pin synchronisers and bus condition decode
  // ************************************************************
  always_comb begin
    s1_d = {i_scl, i_sda};
    s2_d = s1_q;
    s3_d = s2_q;
    rise = s2_q[1] & ~s3_q[1];
    fall = ~s2_q[1] & s3_q[1];
    start = s2_q[1] & s3_q[1] & s3_q[0] & ~s2_q[0];
    stop = s2_q[1] & s3_q[1] & ~s3_q[0] & s2_q[0];
  end

  // byte framing, acknowledge and read data drive
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rsh_d = rsh_q;
    ptr_d = ptr_q;
    oe_d = oe_q;
    stb_d = 1'b0;
    if (start) begin
      st_d = SER_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop) begin
      st_d = SER_IDLE;
      oe_d = 1'b0;
    end else if (st_q != SER_IDLE && rise) begin
      if (cnt_q != SER_ACK_BIT) begin
        sh_d = {sh_q[6:0], s2_q[0]};
        cnt_d = cnt_q + 4'h1;
      end else begin
        cnt_d = 4'h0;
        unique case (st_q)
          SER_ADDR: st_d = sh_q[0] ? SER_RD : SER_REG;
          SER_REG: st_d = SER_WR;
          SER_WR: st_d = SER_WR;
          SER_RD: st_d = s2_q[0] ? SER_IDLE : SER_RD; // nack ends the read
          default: st_d = SER_IDLE;
        endcase
        if (st_d == SER_RD) begin
          rsh_d = bus.rd_data;
          ptr_d = ptr_q + 8'h01;
        end
      end
    end else if (st_q != SER_IDLE && fall) begin
      if (cnt_q == SER_ACK_BIT) begin
        oe_d = 1'b1;
        unique case (st_q)
          SER_ADDR: begin
            if (sh_q[7:1] != SLAVE_ADDR) begin
              st_d = SER_IDLE;
              oe_d = 1'b0;
            end
          end
          SER_REG: ptr_d = sh_q;
          SER_WR: begin
            stb_d = 1'b1;
            ptr_d = ptr_q + 8'h01;
          end
          SER_RD: oe_d = 1'b0; // master acknowledges
          default: oe_d = 1'b0;
        endcase
      end else if (st_q == SER_RD) begin
        oe_d = ~rsh_q[7];
        rsh_d = {rsh_q[6:0], 1'b0};
      end else begin
        oe_d = 1'b0;
      end
    end
  end

  // registers only
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
      st_q <= SER_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rsh_q <= 8'h00;
      ptr_q <= 8'h00;
      oe_q <= 1'b0;
      stb_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rsh_q <= rsh_d;
      ptr_q <= ptr_d;
      oe_q <= oe_d;
      stb_q <= stb_d;
    end
  end

  assign o_sda_oe = oe_q;
  assign bus.wr_stb = stb_q;
  assign bus.wr_addr = ptr_q - 8'h01; // pointer already advanced
  assign bus.wr_data = sh_q;
  assign bus.rd_addr = ptr_q;
endmodule

/* core/lmsq_top.sv */
/*
  Operating-mode sequencer of a nine-output LED driver, with its serial
  register slave and program timebase.
  Assumes i_sys_rst is the power-on reset, i_led_active and o_* control
  lines meet logic on the same clock, and EN, thermal, SCL, SDA and the
  program clock arrive asynchronously from pins or analog comparators.
*/
// How it works
// [RULE1] Writing ff to the reset trigger enters reset mode and reloads every register.
// [RULE2] While the power-on reset is high the sequencer stays in reset mode.
// [RULE3] When the power-on reset releases the sequencer goes straight to standby.
// [RULE4] The run bit is zero after every reset, so nothing starts until the host sets it.
// [RULE5] Outside reset, a low run bit or enable pin holds standby with all functions off.
// [RULE6] In standby, writes are taken while the enable pin is high and act once startup ends.
// [RULE7] Run bit and enable pin both high start the internal blocks and a 500 us delay.
// [RULE8] An over-temperature indication holds the sequencer in startup until it clears.
// [RULE9] After startup, normal mode lets the host control registers drive the block.
// [RULE10] With no LED output active the sequencer enters power-save, analog blocks off.
// [RULE11] The host waits at least 500 us after raising the enable pin before using the bus.
// [RULE12] Program timing pulses follow the external 32.7 kHz clock, faster or slower with it.
// [RULE13] Mode conditions are weighed in order: reset, standby, startup and hot hold, run.
`timescale 1ns/10ps
module lmsq_top #(
  parameter int STARTUP_CYCLES = lmsq_pkg::STARTUP_CYCLES,
  parameter logic [6:0] SLAVE_ADDR = lmsq_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_en_pin,
  input wire logic i_over_temp,
  input wire logic i_led_active,
  input wire logic i_prog_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  output lmsq_pkg::lmsq_mode_type o_mode,
  output logic o_run,
  output logic o_analog_en,
  output logic o_osc_en,
  output logic o_led_en,
  output logic [7:0] o_config,
  output logic o_prog_tick
);
  import lmsq_pkg::*;

  localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  generate
    if (STARTUP_CYCLES < 1) begin : g_bad_delay
      $error("startup delay must be at least one cycle");
    end
  endgenerate

  // ************************************************************
  // declarations
  // ************************************************************
  lmsq_reg_if reg_bus ();

  logic [1:0] pin_s1_q, pin_s2_q, pin_s1_d, pin_s2_d; // {en, over_temp}
  logic en_s, hot_s;
  logic sw_rst_q, sw_rst_d;
  logic [7:0] ctrl_q, ctrl_d, config_q, config_d;
  lmsq_mode_type mode_q, mode_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic analog_q, analog_d, osc_q, osc_d, led_q, led_d;
  logic [7:0] cfg_out_q, cfg_out_d;
  logic run_bit, wr_ok, tick_en;

  // true when a register write hits the given offset
  function automatic logic hit(input logic stb, input logic [7:0] addr,
                               input logic [7:0] target);
    hit = stb & (addr == target);
  endfunction

  // ************************************************************
  // serial slave and program timebase
  // ************************************************************
  lmsq_ser_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_ser (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(o_sda_oe),
    .bus(reg_bus.slave)
  );

  // program ticks run only in the run modes, normal and power-save
  assign tick_en = (mode_q == MODE_NORMAL) | (mode_q == MODE_PSAVE);

  lmsq_prog_tick u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_prog_clk(i_prog_clk),
    .i_enable(tick_en),
    .o_tick(o_prog_tick)
  );

  // ************************************************************
  // pin synchronisers for enable and thermal indication
  // ************************************************************
  always_comb begin
    pin_s1_d = {i_en_pin, i_over_temp};
    pin_s2_d = pin_s1_q;
    en_s = pin_s2_q[1];
    hot_s = pin_s2_q[0];
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  // the key write is registered, then clears everything on the next edge
  always_comb begin
    sw_rst_d = hit(reg_bus.wr_stb, reg_bus.wr_addr, REG_SW_RESET) &
               (reg_bus.wr_data == SW_RESET_KEY); // RULE1
    // writes need the enable pin and a sequencer out of reset
    wr_ok = reg_bus.wr_stb & en_s & ~sw_rst_q & (mode_q != MODE_RESET); // RULE6
    ctrl_d = ctrl_q;
    config_d = config_q;
    if (sw_rst_q) begin
      ctrl_d = CTRL_RESET_VAL; // RULE1
      config_d = CONFIG_RESET_VAL;
    end else begin
      if (hit(wr_ok, reg_bus.wr_addr, REG_CTRL)) begin
        ctrl_d = reg_bus.wr_data;
      end
      if (hit(wr_ok, reg_bus.wr_addr, REG_CONFIG)) begin
        config_d = reg_bus.wr_data; // RULE6
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sw_rst_q <= 1'b0;
      ctrl_q <= CTRL_RESET_VAL; // RULE4
      config_q <= CONFIG_RESET_VAL;
    end else begin
      sw_rst_q <= sw_rst_d;
      ctrl_q <= ctrl_d;
      config_q <= config_d;
    end
  end

  assign run_bit = ctrl_q[CTRL_RUN_BIT];

  // read mux; the reset trigger and unmapped offsets read as zero
  always_comb begin
    unique case (reg_bus.rd_addr)
      REG_CTRL: reg_bus.rd_data = ctrl_q;
      REG_CONFIG: reg_bus.rd_data = config_q;
      REG_STATUS: reg_bus.rd_data = {3'h0, mode_q};
      default: reg_bus.rd_data = READ_ZERO;
    endcase
  end

  // ************************************************************
  // mode sequencer
  // ************************************************************
  // conditions are checked from the strongest down
  always_comb begin
    mode_d = mode_q;
    cnt_d = cnt_q;
    if (sw_rst_q) begin
      mode_d = MODE_RESET; // RULE1 RULE13
      cnt_d = CNT_ZERO;
    end else if (mode_q == MODE_RESET) begin
      mode_d = MODE_STANDBY; // RULE3
    end else if (!(run_bit && en_s)) begin
      mode_d = MODE_STANDBY; // RULE5 RULE13
      cnt_d = CNT_ZERO;
    end else begin
      unique case (mode_q)
        MODE_STANDBY: begin
          mode_d = MODE_STARTUP; // RULE7
          cnt_d = CNT_ZERO;
        end
        MODE_STARTUP: begin
          // the delay only advances while the die is cool
          if (!hot_s) begin // RULE8
            if (cnt_q == CNT_LAST) begin
              mode_d = i_led_active ? MODE_NORMAL : MODE_PSAVE; // RULE7 RULE9
            end else begin
              cnt_d = cnt_q + CNT_W'(1);
            end
          end
        end
        MODE_NORMAL: begin
          if (hot_s) begin
            mode_d = MODE_STARTUP; // RULE8
            cnt_d = CNT_ZERO;
          end else if (!i_led_active) begin
            mode_d = MODE_PSAVE; // RULE10
          end
        end
        MODE_PSAVE: begin
          if (hot_s) begin
            mode_d = MODE_STARTUP; // RULE8
            cnt_d = CNT_ZERO;
          end else if (i_led_active) begin
            mode_d = MODE_NORMAL; // RULE9
          end
        end
        default: begin
          mode_d = MODE_RESET;
          cnt_d = CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_q <= MODE_RESET; // RULE2
      cnt_q <= CNT_ZERO;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
    end
  end

  // ************************************************************
  // block enables, registered from the next mode
  // ************************************************************
  always_comb begin
    // reference, bias and oscillator are up in startup and normal
    analog_d = (mode_d == MODE_STARTUP) | (mode_d == MODE_NORMAL); // RULE7 RULE10
    osc_d = (mode_d == MODE_STARTUP) | (mode_d == MODE_NORMAL);
    // host settings only reach the drivers in the run modes
    led_d = (mode_d == MODE_NORMAL); // RULE9
    cfg_out_d = ((mode_d == MODE_NORMAL) | (mode_d == MODE_PSAVE)) ?
                config_d : CONFIG_RESET_VAL; // RULE9
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      analog_q <= 1'b0;
      osc_q <= 1'b0;
      led_q <= 1'b0;
      cfg_out_q <= CONFIG_RESET_VAL;
    end else begin
      analog_q <= analog_d;
      osc_q <= osc_d;
      led_q <= led_d;
      cfg_out_q <= cfg_out_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_sda = 1'b0; // open drain: only ever pulls low
  assign o_mode = mode_q;
  assign o_run = ctrl_q[CTRL_RUN_BIT];
  assign o_analog_en = analog_q;
  assign o_osc_en = osc_q;
  assign o_led_en = led_q;
  assign o_config = cfg_out_q;
endmodule

/* pkg/lmsq_pkg.sv */
/*
  Shared constants and types of the LED driver mode sequencer: register
  offsets, reset values, the mode and serial-slave state encodings, timing.
  Assumes a single 10 MHz system clock and a synchronous active-high reset.
*/
package lmsq_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;       // run bit lives here
  localparam logic [7:0] REG_CONFIG = 8'h01;     // host control settings
  localparam logic [7:0] REG_STATUS = 8'h02;     // current mode, read only
  localparam logic [7:0] REG_SW_RESET = 8'h3d;   // write only reset trigger
  localparam logic [7:0] SW_RESET_KEY = 8'hff;   // value that fires a reset
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
  localparam logic [7:0] CONFIG_RESET_VAL = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h32;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int STARTUP_DELAY_US = 500;
  localparam int STARTUP_CYCLES = STARTUP_DELAY_US * (CLK_FREQ_HZ / HZ_PER_MHZ);
  localparam int PROG_CLK_NOMINAL_HZ = 32_700;   // nominal program clock

  // ************************************************************
  // encodings
  // ************************************************************
  typedef enum logic [4:0] {
    MODE_RESET   = 5'b00001,
    MODE_STANDBY = 5'b00010,
    MODE_STARTUP = 5'b00100,
    MODE_NORMAL  = 5'b01000,
    MODE_PSAVE   = 5'b10000
  } lmsq_mode_type;

  typedef enum logic [4:0] {
    SER_IDLE = 5'b00001,
    SER_ADDR = 5'b00010,
    SER_REG  = 5'b00100,
    SER_WR   = 5'b01000,
    SER_RD   = 5'b10000
  } lmsq_ser_type;

  localparam logic [3:0] SER_ACK_BIT = 4'h8;

endpackage

/* pkg/lmsq_reg_if.sv */
/*
  Register access path between the serial slave and the register file.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface lmsq_reg_if;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  modport slave (output wr_stb, output wr_addr, output wr_data, output rd_addr,
                 input rd_data);
  modport regs (input wr_stb, input wr_addr, input wr_data, input rd_addr,
                output rd_data);
endinterface
